// >>> rtl/tpct_cfg.svh
/*
 tape punch code translator: register offsets, field positions, reset values, timing.
 assumes inclusion by bare name from the design file and the testbench.
*/
`ifndef TPCT_CFG_SVH
`define TPCT_CFG_SVH
`define TPCT_OFF_CTRL 12'h000
`define TPCT_OFF_STATUS 12'h004
`define TPCT_OFF_EMIT 12'h008
`define TPCT_OFF_CODES 12'h00C
`define TPCT_OFF_STOP 12'h010
`define TPCT_OFF_MERGE 12'h014
`define TPCT_OFF_EXCSET 12'h018
`define TPCT_OFF_SHMASK_LO 12'h01C
`define TPCT_OFF_SHMASK_HI 12'h020
`define TPCT_OFF_TABLE 12'h100
`define TPCT_CTRL_EN 0
`define TPCT_CTRL_REMOTE 1
`define TPCT_CTRL_LEVEL_LSB 2
`define TPCT_CTRL_ACT_LSB 4
`define TPCT_STAT_NOT_READY 0
`define TPCT_STAT_LOW_TAPE 1
`define TPCT_STAT_STOPPED 2
`define TPCT_STAT_BUSY 3
`define TPCT_STAT_SHIFTED 4
`define TPCT_CODE_EN 6
`define TPCT_TBL_VALID 8
`define TPCT_CTRL_RST 32'h0000000C
`define TPCT_CLK_PERIOD_NS 100
`define TPCT_FEED_PERIOD_NS 10000000
`define TPCT_FEED_FRAME 8'hFF
`define TPCT_RESP_OKAY 2'h0
`define TPCT_RESP_SLVERR 2'h2
`endif

// >>> rtl/tpct_pkg.sv
/*
 tape punch code translator: shared types.
 assumes nothing beyond the constants header.
*/
package tpct_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_FEED = 3'b100
	} tpct_state_t;
	typedef enum logic [1:0] {
		ACT_OFF = 2'h0,
		ACT_PUNCH_STOP = 2'h1,
		ACT_DEL_STOP = 2'h2,
		ACT_DEL_CONT = 2'h3
	} tpct_act_t;
endpackage

// >>> rtl/tpct_translator.sv
/*
 tape punch code translator: AXI4-Lite register slave, 64-cell translation table,
 case-shift insertion, exception frame, stop and control codes, tape feed.
 assumes characters arrive on i_clk from the I/O control unit after channel select,
 and the punch answers each frame with i_punch_ready on the same clock.
// Summary of operation
// - column index is the two zone bits, character bits five and six
// - row index is the four numeric bits, character bits one to four
// - output column value drives channels one to four, lsb on channel one
// - output row value drives channels five to eight, lsb on channel five
// - up to 64 input codes map onto 5 to 8 channel codes
// - four stop detectors; an unmapped stop code is suppressed
// - a mask marks codes needing shift case; others need unshift
// - a case change punches the shift or unshift code
// - shift code is a programmable 8-bit value
// - unshift code is a programmable 8-bit value for unmarked codes
// - a merge group lets three input codes share one output code
// - carriage return, tab, line feed, space, end of line are unshift
// - end of line punches the exception code, then its own code
// - exception code is a programmable 8-bit value, end of line only
// - translator disabled gives the default internal to tape code mapping
// - characters flow channel select, translator, punch, in order
// - local mode refuses host characters; remote mode accepts them
// - tape feed works only in local, all holes, 100 frames per second
// - low tape status follows the 35 foot supply sensor
// - level setting selects how many channels are punched
// - not-ready status blocks further host output
// - case change frame goes before the character needing it
*/
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tpct_cfg.svh"
module tpct_translator #(
	parameter int FEED_CYCLES = `TPCT_FEED_PERIOD_NS / `TPCT_CLK_PERIOD_NS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [11:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [11:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [6:0] i_char,
	input wire logic i_char_valid,
	output logic o_char_ready,
	output logic [7:0] o_punch_data,
	output logic o_punch_valid,
	input wire logic i_punch_ready,
	input wire logic i_tape_feed,
	input wire logic i_low_tape,
	output logic o_low_tape,
	output logic o_not_ready
);
	localparam int FEED_W = $clog2(FEED_CYCLES + 1);
	localparam logic [FEED_W-1:0] FEED_RELOAD = FEED_W'(FEED_CYCLES - 2); // valid and take count too
	logic [31:0] ctrl_r, emit_r, codes_r, stop_r, merge_r, excset_r, shm_lo_r, shm_hi_r;
	logic [8:0] tbl_r [64];
	logic stopped_r, shifted_r, feed_m_r, feed_s_r, low_m_r, low_s_r;
	tpct_pkg::tpct_state_t st_r;
	logic [2:0] pend_r;
	logic [7:0] frm_r [3];
	logic [FEED_W-1:0] feed_cnt_r;
	logic [7:0] punch_r;
	logic pvalid_r;
	// register bus state
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic wr_fire, wr_tbl, wr_hit;
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction
	function automatic logic code_hit(input logic [6:0] slot, input logic [5:0] code);
		return slot[`TPCT_CODE_EN] && (slot[5:0] == code);
	endfunction
	assign o_awready = !aw_got_r && !bvalid_r;
	assign o_wready = !w_got_r && !bvalid_r;
	assign o_bvalid = bvalid_r;
	assign o_bresp = bresp_r;
	assign o_arready = !rvalid_r;
	assign o_rvalid = rvalid_r;
	assign o_rdata = rdata_r;
	assign o_rresp = rresp_r;
	assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
	assign wr_tbl = awaddr_r[11:8] == `TPCT_OFF_TABLE >> 8;
	always_comb begin
		unique case ({awaddr_r[11:2], 2'h0})
			`TPCT_OFF_CTRL, `TPCT_OFF_STATUS, `TPCT_OFF_EMIT, `TPCT_OFF_CODES, `TPCT_OFF_STOP,
			`TPCT_OFF_MERGE, `TPCT_OFF_EXCSET, `TPCT_OFF_SHMASK_LO, `TPCT_OFF_SHMASK_HI:
				wr_hit = 1'b1;
			default:
				wr_hit = wr_tbl;
		endcase
	end
	// address and data are taken in either order; the response waits for both
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bresp_r <= `TPCT_RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= i_wdata;
				wstrb_r <= i_wstrb;
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? `TPCT_RESP_OKAY : `TPCT_RESP_SLVERR;
			end else if (bvalid_r && i_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_r <= `TPCT_CTRL_RST;
			emit_r <= 32'h00000000;
			codes_r <= 32'h00000000;
			stop_r <= 32'h00000000;
			merge_r <= 32'h00000000;
			excset_r <= 32'h00000000;
			shm_lo_r <= 32'h00000000;
			shm_hi_r <= 32'h00000000;
		end else if (wr_fire) begin
			unique case ({awaddr_r[11:2], 2'h0})
				`TPCT_OFF_CTRL: ctrl_r <= merge_bytes(ctrl_r, wdata_r, wstrb_r) & 32'h0000003F;
				`TPCT_OFF_EMIT: emit_r <= merge_bytes(emit_r, wdata_r, wstrb_r) & 32'h00FFFFFF;
				`TPCT_OFF_CODES: codes_r <= merge_bytes(codes_r, wdata_r, wstrb_r) & 32'h00007F7F;
				`TPCT_OFF_STOP: stop_r <= merge_bytes(stop_r, wdata_r, wstrb_r) & 32'h7F7F7F7F;
				`TPCT_OFF_MERGE: merge_r <= merge_bytes(merge_r, wdata_r, wstrb_r) & 32'hFF7F7F7F;
				`TPCT_OFF_EXCSET: excset_r <= merge_bytes(excset_r, wdata_r, wstrb_r) & 32'h7F7F7F7F;
				`TPCT_OFF_SHMASK_LO: shm_lo_r <= merge_bytes(shm_lo_r, wdata_r, wstrb_r);
				`TPCT_OFF_SHMASK_HI: shm_hi_r <= merge_bytes(shm_hi_r, wdata_r, wstrb_r);
				default: ;
			endcase
		end
	end
	// table cell: bits 3:0 output column, 7:4 output row, 8 cell mapped
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < 64; i++) begin
				tbl_r[i] <= 9'h000;
			end
		end else if (wr_fire && wr_tbl) begin
			if (wstrb_r[0]) begin
				tbl_r[awaddr_r[7:2]][7:0] <= wdata_r[7:0];
			end
			if (wstrb_r[1]) begin
				tbl_r[awaddr_r[7:2]][8] <= wdata_r[`TPCT_TBL_VALID];
			end
		end
	end
	logic [31:0] status;
	logic [31:0] rd_val;
	logic rd_hit;
	assign status = {27'h0, shifted_r, st_r != tpct_pkg::ST_IDLE, stopped_r, o_low_tape, o_not_ready};
	always_comb begin
		rd_hit = 1'b1;
		unique case ({i_araddr[11:2], 2'h0})
			`TPCT_OFF_CTRL: rd_val = ctrl_r;
			`TPCT_OFF_STATUS: rd_val = status;
			`TPCT_OFF_EMIT: rd_val = emit_r;
			`TPCT_OFF_CODES: rd_val = codes_r;
			`TPCT_OFF_STOP: rd_val = stop_r;
			`TPCT_OFF_MERGE: rd_val = merge_r;
			`TPCT_OFF_EXCSET: rd_val = excset_r;
			`TPCT_OFF_SHMASK_LO: rd_val = shm_lo_r;
			`TPCT_OFF_SHMASK_HI: rd_val = shm_hi_r;
			default: begin
				rd_hit = i_araddr[11:8] == `TPCT_OFF_TABLE >> 8;
				rd_val = rd_hit ? {23'h0, tbl_r[i_araddr[7:2]]} : 32'h00000000;
			end
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `TPCT_RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_hit ? `TPCT_RESP_OKAY : `TPCT_RESP_SLVERR;
		end else if (rvalid_r && i_rready) begin
			rvalid_r <= 1'b0;
		end
	end
	// operator pins come from outside the clock domain; only the second stage is cleared
	always_ff @(posedge i_clk) begin
		feed_m_r <= i_tape_feed;
		low_m_r <= i_low_tape;
		feed_s_r <= feed_m_r && !i_rst;
		low_s_r <= low_m_r && !i_rst;
	end
	assign o_low_tape = low_s_r;
	// character decode
	logic enable, remote, accept, mapped, exc, el_hit, stop_hit, need_shift, del, stop_act;
	logic merge_hit, ctrl_hit, skip_chr;
	logic [5:0] idx;
	logic [7:0] chr_code, lvl_mask;
	logic [63:0] shmask;
	tpct_pkg::tpct_act_t act;
	assign enable = ctrl_r[`TPCT_CTRL_EN];
	assign remote = ctrl_r[`TPCT_CTRL_REMOTE];
	assign act = tpct_pkg::tpct_act_t'(ctrl_r[`TPCT_CTRL_ACT_LSB +: 2]);
	assign shmask = {shm_hi_r, shm_lo_r};
	assign idx = {i_char[5:4], i_char[3:0]};
	assign merge_hit = code_hit(merge_r[6:0], idx) || code_hit(merge_r[14:8], idx)
		|| code_hit(merge_r[22:16], idx);
	assign mapped = merge_hit || tbl_r[idx][`TPCT_TBL_VALID];
	// row nibble lands on channels 5-8, column nibble on channels 1-4
	always_comb begin
		if (!enable) begin
			chr_code = {1'b0, i_char};
		end else if (merge_hit) begin
			chr_code = merge_r[31:24];
		end else begin
			chr_code = {tbl_r[idx][7:4], tbl_r[idx][3:0]};
		end
	end
	assign el_hit = enable && code_hit(codes_r[6:0], idx);
	assign exc = el_hit || code_hit(excset_r[6:0], idx) || code_hit(excset_r[14:8], idx)
		|| code_hit(excset_r[22:16], idx) || code_hit(excset_r[30:24], idx);
	assign need_shift = enable && shmask[idx] && !exc;
	assign stop_hit = enable && (code_hit(stop_r[6:0], idx) || code_hit(stop_r[14:8], idx)
		|| code_hit(stop_r[22:16], idx) || code_hit(stop_r[30:24], idx));
	assign ctrl_hit = act != tpct_pkg::ACT_OFF && code_hit(codes_r[14:8], idx);
	assign del = ctrl_hit && act != tpct_pkg::ACT_PUNCH_STOP;
	assign stop_act = ctrl_hit && act != tpct_pkg::ACT_DEL_CONT;
	assign skip_chr = del || (stop_hit && !mapped);
	always_comb begin
		unique case (ctrl_r[`TPCT_CTRL_LEVEL_LSB +: 2])
			2'h0: lvl_mask = 8'h1F;
			2'h1: lvl_mask = 8'h3F;
			2'h2: lvl_mask = 8'h7F;
			default: lvl_mask = 8'hFF;
		endcase
	end
	assign o_not_ready = stopped_r || !remote;
	// one character at a time; nothing is taken while frames remain
	assign o_char_ready = st_r == tpct_pkg::ST_IDLE && remote && !stopped_r;
	assign accept = i_char_valid && o_char_ready;
	// pending frames in punch order: case code, exception, character
	logic [2:0] pend_new, pend_left;
	logic [7:0] frm_new [3];
	logic hs;
	assign hs = o_punch_valid && i_punch_ready;
	assign pend_new = {!skip_chr, el_hit && !skip_chr,
		enable && !skip_chr && (need_shift != shifted_r)};
	assign frm_new[0] = need_shift ? emit_r[7:0] : emit_r[15:8];
	assign frm_new[1] = emit_r[23:16];
	assign frm_new[2] = chr_code;
	assign pend_left = pend_r & (pend_r - 3'h1);
	function automatic logic [7:0] first_frame(input logic [2:0] p, input logic [7:0] f0,
			input logic [7:0] f1, input logic [7:0] f2);
		return p[0] ? f0 : (p[1] ? f1 : f2);
	endfunction
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= tpct_pkg::ST_IDLE;
			pend_r <= 3'h0;
			pvalid_r <= 1'b0;
			punch_r <= 8'h00;
			feed_cnt_r <= '0;
			for (int i = 0; i < 3; i++) begin
				frm_r[i] <= 8'h00;
			end
		end else begin
			unique case (st_r)
				tpct_pkg::ST_IDLE: begin
					if (accept && pend_new != 3'h0) begin
						st_r <= tpct_pkg::ST_RUN;
						pend_r <= pend_new;
						frm_r <= frm_new;
						pvalid_r <= 1'b1;
						punch_r <= first_frame(pend_new, frm_new[0], frm_new[1], frm_new[2])
							& lvl_mask;
					end else if (!remote && feed_s_r) begin
						st_r <= tpct_pkg::ST_FEED;
						feed_cnt_r <= '0;
					end
				end
				tpct_pkg::ST_RUN: begin
					if (hs) begin
						pend_r <= pend_left;
						punch_r <= first_frame(pend_left, frm_r[0], frm_r[1], frm_r[2]) & lvl_mask;
						if (pend_left == 3'h0) begin
							pvalid_r <= 1'b0;
							st_r <= tpct_pkg::ST_IDLE;
						end
					end
				end
				tpct_pkg::ST_FEED: begin
					if (hs) begin
						pvalid_r <= 1'b0;
						feed_cnt_r <= FEED_RELOAD;
					end else if (!pvalid_r && feed_cnt_r != '0) begin
						feed_cnt_r <= feed_cnt_r - FEED_W'(1);
					end else if (!pvalid_r && feed_s_r && !remote) begin
						pvalid_r <= 1'b1;
						punch_r <= `TPCT_FEED_FRAME & lvl_mask;
					end else if (!pvalid_r) begin
						st_r <= tpct_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end
	assign o_punch_valid = pvalid_r;
	assign o_punch_data = punch_r;
	// case state and stop flag; a new stop wins over a software clear
	logic stop_clr;
	assign stop_clr = wr_fire && {awaddr_r[11:2], 2'h0} == `TPCT_OFF_STATUS && wstrb_r[0]
		&& wdata_r[`TPCT_STAT_STOPPED];
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			shifted_r <= 1'b0;
			stopped_r <= 1'b0;
		end else begin
			if (accept && enable && !skip_chr) begin
				shifted_r <= need_shift;
			end
			if (accept && (stop_act || stop_hit)) begin
				stopped_r <= 1'b1;
			end else if (stop_clr) begin
				stopped_r <= 1'b0;
			end
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_local_refuses: assert property (!remote |-> !o_char_ready)
		else $error("character accepted in local mode");
	a_hold_off_busy: assert property (o_punch_valid && !i_punch_ready |=> !o_char_ready)
		else $error("next character allowed while frames pending");
	a_frame_stable: assert property (o_punch_valid && !i_punch_ready |=> $stable(o_punch_data))
		else $error("punch frame changed before taken");
	a_level_mask: assert property (o_punch_valid |-> (o_punch_data & ~lvl_mask) == 8'h00)
		else $error("channel above level punched");
	a_bypass_code: assert property (accept && !enable && !del
		|=> o_punch_data == ({1'b0, $past(i_char)} & $past(lvl_mask)))
		else $error("default mapping wrong");
	a_shift_first: assert property (accept && pend_new[0] && need_shift
		|=> o_punch_data == (emit_r[7:0] & lvl_mask))
		else $error("shift code not punched first");
	a_exc_before: assert property (accept && el_hit && !skip_chr && !pend_new[0]
		|=> pend_r == 3'b110 && o_punch_data == (emit_r[23:16] & lvl_mask))
		else $error("exception code not punched first");
	a_char_after: assert property (hs && pend_r == 3'b110
		|=> o_punch_valid && o_punch_data == (frm_r[2] & lvl_mask))
		else $error("character not punched after exception code");
	a_stop_suppress: assert property (accept && stop_hit && !mapped && !ctrl_hit |=> !o_punch_valid ##1 stopped_r)
		else $error("unmapped stop code punched");
	a_low_tape: assert property (i_low_tape [*3] |-> o_low_tape)
		else $error("low tape not reported");
	a_not_ready: assert property (stopped_r |-> o_not_ready && !o_char_ready)
		else $error("stopped but ready");
	c_shift_insert: cover property (accept && pend_new[0] && pend_new[2]);
	c_el_sequence: cover property (accept && el_hit && pend_new[1]);
	c_feed_frame: cover property (st_r == tpct_pkg::ST_FEED && hs);
	c_ctrl_stop: cover property (accept && stop_act);
endmodule // tpct_translator
`default_nettype wire

// >>> testbench/tpct_punch_model.sv
/*
 paper tape punch model: takes frames from the translator, promptly or slowly.
 assumes the translator's punch port on the same clock; o_got pulses the cycle after a take.
*/
`timescale 1ns/1ps
`default_nettype none
module tpct_punch_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_punch_data,
	input wire logic i_punch_valid,
	input wire logic i_slow,
	output logic o_punch_ready,
	output logic o_got,
	output logic [7:0] o_frame
);
	logic [1:0] pace_r;
	// slow mode takes one edge in four, so frames wait on the punch mechanism
	always_ff @(posedge i_clk) begin
		if (i_rst) pace_r <= 2'h0;
		else pace_r <= pace_r + 2'h1;
	end
	assign o_punch_ready = !i_slow || (pace_r == 2'h3);
	always_ff @(posedge i_clk) begin
		o_got <= !i_rst && i_punch_valid && o_punch_ready;
		o_frame <= i_punch_data;
	end
endmodule // tpct_punch_model
`default_nettype wire

// >>> testbench/tb.sv
/*
 self-checking bench for the tape punch code translator, with a queue model of frames.
 assumes tpct_translator and tpct_punch_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tpct_cfg.svh"
module tb;
	localparam logic [5:0] EOL_C = 6'h1A;
	localparam logic [5:0] EXC_C = 6'h10;
	localparam logic [5:0] STOP_C = 6'h3F;
	localparam logic [7:0] SH = 8'h1B;
	localparam logic [7:0] UN = 8'h1F;
	localparam logic [7:0] EXC = 8'h42;
	logic i_clk, i_rst, awvalid, wvalid, bready, arvalid, rready, ch_valid, feed, low_in, slow;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, seed, rd;
	logic [6:0] ch, nc;
	logic [1:0] rs;
	logic [7:0] lm;
	wire logic awready, wready, bvalid, arready, rvalid, ch_ready, p_valid, p_ready, got;
	wire logic low_out, not_ready;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] p_data, frame;
	int n_errors, tests_run, n_frames, base;
	logic [7:0] expq[$];
	logic [7:0] code[64];
	logic [63:0] shm;
	logic feed_mode, cur_sh;
	tpct_translator #(.FEED_CYCLES(8)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_char(ch), .i_char_valid(ch_valid), .o_char_ready(ch_ready),
		.o_punch_data(p_data), .o_punch_valid(p_valid), .i_punch_ready(p_ready),
		.i_tape_feed(feed), .i_low_tape(low_in), .o_low_tape(low_out), .o_not_ready(not_ready));
	tpct_punch_model u_punch (.i_clk(i_clk), .i_rst(i_rst), .i_punch_data(p_data),
		.i_punch_valid(p_valid), .i_slow(slow), .o_punch_ready(p_ready), .o_got(got),
		.o_frame(frame));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic end_sim();
		$display("errors %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bump(inout int n);
		n++;
		if (n > 500) begin
			n_errors++;
			$display("wait ran out at %0t", $time);
			end_sim();
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic a_ok, w_ok, b_ok;
		n = 0;
		b_ok = 1'b0;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_ok) begin
			@(negedge i_clk);
			bump(n);
			a_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bvalid && bready;
			if (b_ok) check(bresp, er);
			@(posedge i_clk);
			if (a_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
			if (b_ok) bready <= 1'b0;
		end
	endtask
	task automatic axi_rd(input logic [11:0] a);
		int n;
		logic a_ok, r_ok;
		n = 0;
		r_ok = 1'b0;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_ok) begin
			@(negedge i_clk);
			bump(n);
			a_ok = arvalid && arready;
			r_ok = rvalid && rready;
			rd = rdata;
			rs = rresp;
			@(posedge i_clk);
			if (a_ok) arvalid <= 1'b0;
			if (r_ok) rready <= 1'b0;
		end
	endtask
	task automatic send(input logic [6:0] c);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		@(posedge i_clk);
		ch <= c;
		ch_valid <= 1'b1;
		while (!ok) begin
			@(negedge i_clk);
			bump(n);
			ok = ch_ready;
			@(posedge i_clk);
		end
		ch_valid <= 1'b0;
	endtask
	task automatic predict(input logic [6:0] c);
		logic nd;
		nd = shm[c[5:0]] && (c[5:0] != EXC_C);
		if (nd !== cur_sh) expq.push_back((nd ? SH : UN) & lm);
		cur_sh = nd;
		if (c[5:0] == EOL_C) expq.push_back(EXC & lm);
		expq.push_back(code[c[5:0]] & lm);
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (expq.size() != 0) begin
			@(negedge i_clk);
			bump(n);
		end
	endtask
	always @(negedge i_clk) begin
		if (got) begin
			n_frames++;
			if (feed_mode) check(frame, `TPCT_FEED_FRAME);
			else if (expq.size() == 0) check(32'h100 | frame, 32'h0);
			else check(frame, expq.pop_front());
		end
	end
	initial begin
		{i_rst, awvalid, wvalid, bready, arvalid, rready, ch_valid, feed, low_in, slow} = 10'h200;
		{awaddr, araddr, wdata, ch} = '0;
		{n_errors, tests_run, n_frames, feed_mode, cur_sh} = '0;
		seed = 32'd14;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		axi_rd(`TPCT_OFF_CTRL);
		check(rd, `TPCT_CTRL_RST);
		axi_rd(12'h040);
		check(rs, `TPCT_RESP_SLVERR);
		check(rd, 32'h0);
		for (int lv = 0; lv < 4; lv++) begin
			axi_wr(`TPCT_OFF_CTRL, 32'(2 | (lv << 2)), `TPCT_RESP_OKAY);
			lm = 8'hFF >> (3 - lv);
			slow <= lv[0];
			for (int k = 0; k < 4; k++) begin
				seed = xs(seed);
				expq.push_back({1'b0, seed[6:0]} & lm);
				send(seed[6:0]);
			end
			drain();
		end
		// remote but no local mode: the feed switch must punch nothing
		feed <= 1'b1;
		repeat (20) @(posedge i_clk);
		feed <= 1'b0;
		for (int i = 0; i < 64; i++) begin
			seed = xs(seed);
			code[i] = seed[7:0];
			axi_wr(12'(`TPCT_OFF_TABLE + 4 * i), {23'h0, i != STOP_C, code[i]}, `TPCT_RESP_OKAY);
		end
		seed = xs(seed);
		shm = {seed, xs(seed)} & {2{32'h55555555}}; // no more than 32 shift marks
		shm[EOL_C] = 1'b0;
		shm[EXC_C] = 1'b1;
		axi_wr(`TPCT_OFF_SHMASK_LO, shm[31:0], `TPCT_RESP_OKAY);
		axi_wr(`TPCT_OFF_SHMASK_HI, shm[63:32], `TPCT_RESP_OKAY);
		axi_wr(`TPCT_OFF_EMIT, {8'h00, EXC, UN, SH}, `TPCT_RESP_OKAY);
		axi_wr(`TPCT_OFF_CODES, {26'h1, EOL_C}, `TPCT_RESP_OKAY);
		axi_wr(`TPCT_OFF_STOP, {26'h1, STOP_C}, `TPCT_RESP_OKAY);
		axi_wr(`TPCT_OFF_EXCSET, {26'h1, EXC_C}, `TPCT_RESP_OKAY);
		axi_wr(`TPCT_OFF_CTRL, 32'h0000000F, `TPCT_RESP_OKAY);
		lm = 8'hFF;
		for (int k = 0; k < 40; k++) begin
			seed = xs(seed);
			nc = {seed[9], (k % 8 == 0) ? EOL_C : (k % 8 == 4) ? EXC_C : 6'(seed % 63)};
			slow <= k[3];
			predict(nc);
			send(nc);
		end
		drain();
		axi_rd(`TPCT_OFF_STATUS);
		check(rd[`TPCT_STAT_SHIFTED], cur_sh);
		send({1'b1, STOP_C});
		repeat (6) @(posedge i_clk);
		@(negedge i_clk);
		check({not_ready, ch_ready}, 2'b10);
		axi_rd(`TPCT_OFF_STATUS);
		check(rd[`TPCT_STAT_STOPPED], 1'b1);
		axi_wr(`TPCT_OFF_STATUS, 32'h4, `TPCT_RESP_OKAY);
		@(negedge i_clk);
		check(not_ready, 1'b0);
		// merge group 05/07 -> A5, control code 09 deleted, then punched with a stop
		axi_wr(`TPCT_OFF_MERGE, 32'hA5004745, `TPCT_RESP_OKAY);
		axi_wr(`TPCT_OFF_CODES, {16'h0, 8'h49, 2'h1, EOL_C}, `TPCT_RESP_OKAY);
		code[5] = 8'hA5;
		code[7] = 8'hA5;
		axi_wr(`TPCT_OFF_CTRL, 32'h0000003F, `TPCT_RESP_OKAY);
		for (int k = 0; k < 6; k++) begin
			nc = 7'((k % 3 == 0) ? 5 : (k % 3 == 1) ? 7 : 9);
			if (nc != 7'h09) predict(nc);
			send(nc);
		end
		drain();
		check(not_ready, 1'b0);
		axi_wr(`TPCT_OFF_CTRL, 32'h0000001F, `TPCT_RESP_OKAY);
		predict(7'h09);
		send(7'h09);
		drain();
		check(not_ready, 1'b1);
		axi_wr(`TPCT_OFF_STATUS, 32'h4, `TPCT_RESP_OKAY);
		predict(7'h01);
		send(7'h01);
		drain();
		low_in <= 1'b1;
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		check(low_out, 1'b1);
		axi_rd(`TPCT_OFF_STATUS);
		check(rd[`TPCT_STAT_LOW_TAPE], 1'b1);
		axi_wr(`TPCT_OFF_CTRL, 32'h0000000D, `TPCT_RESP_OKAY);
		@(negedge i_clk);
		check({not_ready, ch_ready}, 2'b10);
		feed_mode = 1'b1;
		base = n_frames;
		@(posedge i_clk);
		feed <= 1'b1;
		repeat (40) @(posedge i_clk);
		feed <= 1'b0;
		repeat (20) @(posedge i_clk);
		feed_mode = 1'b0;
		// 40 cycles of switch at one frame each 8 cycles
		check(n_frames - base, 5);
		end_sim();
	end
endmodule // tb
`default_nettype wire
